// ===== rssd_pkg.sv
package rssd_pkg;

  localparam int DATA_W = 8;
  localparam int MSB = 7;
  localparam int LSB = 0;
  localparam int BIT_SEL_W = 3;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] SET_BYTE_VALUE = 8'hFF;
  localparam logic [7:0] ONE = 8'h01;
  localparam int SKIP_CYCLES = 2;
  localparam int NORMAL_CYCLES = 1;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_LEFT_VIA_CY_MEM,
    OP_ROTATE_LEFT_VIA_CY_TO_ACC,
    OP_ROTATE_RIGHT_MEM,
    OP_ROTATE_RIGHT_TO_ACC,
    OP_ROTATE_RIGHT_VIA_CARRY_MEM,
    OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC,
    OP_SUB_BORROW_TO_ACCUMULATOR,
    OP_SUB_BORROW_TO_MEMORY,
    OP_SUBTRACT_TO_ACC,
    OP_SUBTRACT_TO_MEMORY,
    OP_SUBTRACT_IMMEDIATE,
    OP_DECREMENT_SKIP_ZERO,
    OP_DECREMENT_TO_ACC_SKIP_ZERO,
    OP_SET_BYTE,
    OP_SET_BIT,
    OP_INCREMENT_SKIP_ZERO,
    OP_INCREMENT_TO_ACC_SKIP_ZERO,
    OP_BIT_TEST_SKIP_SET,
    OP_NIBBLE_SWAP_MEM,
    OP_NIBBLE_EXCHANGE_TO_ACC
  } rssd_op_e;

endpackage : rssd_pkg

// ===== rssd_alu_if.sv
interface rssd_alu_if;
  logic [7:0] acc;
  logic [7:0] mem;
  logic carry_in;
  logic [7:0] sum;
  logic carry_out;
  logic nibble_carry;
  logic sign_error;

  modport core (output acc, output mem, output carry_in, input sum, input carry_out, input nibble_carry,
    input sign_error);
  modport alu (input acc, input mem, input carry_in, output sum, output carry_out, output nibble_carry,
    output sign_error);
endinterface : rssd_alu_if

// ===== rssd_sub_alu.sv
module rssd_sub_alu (
  rssd_alu_if.alu port
);

  logic [4:0] low;
  logic [8:0] full;
  logic [7:0] inv;

  // Subtraction is an add of the inverted operand; carry set means no borrow.
  always_comb begin
    inv = ~port.mem;
    low = {1'b0, port.acc[3:0]} + {1'b0, inv[3:0]} + {4'h0, port.carry_in};
    full = {1'b0, port.acc} + {1'b0, inv} + {8'h00, port.carry_in};
    port.sum = full[7:0];
    port.carry_out = full[8];
    port.nibble_carry = low[4];
    port.sign_error = (port.acc[7] == inv[7]) && (full[7] != port.acc[7]);
  end

endmodule : rssd_sub_alu

// ===== rssd_datapath.sv
// Notes on behaviour
// - Rotate memory left through carry, carry only.
// - Left rotate via carry into accumulator.
// - Rotate memory right, no flags.
// - Rotate right into accumulator, no flags.
// - Rotate memory right through carry, carry only.
// - Right rotate via carry into accumulator.
// - Subtract with borrow, four flags updated.
// - Subtract memory byte, four flags updated.
// - Subtract immediate into accumulator, flags updated.
// - Decrement memory, skip when zero.
// - Decrement into accumulator, skip when zero.
// - Skip discards prefetch, adds one dummy cycle.
// - Set byte writes all ones.
// - Set bit sets only selected bit.
// - Increment memory, skip when zero.
// - Increment into accumulator, skip when zero.
// - Bit test skips when bit set.
// - Swap memory nibbles in place.
// - Nibble exchange into accumulator.
module rssd_datapath (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Instruction issue
  input wire logic op_valid,
  input wire rssd_pkg::rssd_op_e op_code,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] imm_data,
  input wire logic [2:0] bit_sel,
  // Memory write
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // Architectural state
  output logic [7:0] acc,
  output logic carry_flag,
  output logic zero_flag,
  output logic nibble_carry_flag,
  output logic sign_error_flag,
  // Sequencing
  output logic skip_flush,
  output logic busy
);

  rssd_alu_if alu_bus ();

  logic [7:0] next_acc;
  logic next_carry_flag;
  logic next_zero_flag;
  logic next_nibble_carry_flag;
  logic next_sign_error_flag;
  logic next_mem_we;
  logic [7:0] next_mem_wdata;
  logic next_skip_flush;
  logic next_busy;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  // A net, because each bit of the mask is driven by its own generate branch.
  wire logic [7:0] bit_mask;
  logic skip_cond;

  rssd_sub_alu u_alu (
    .port(alu_bus)
  );

  assign dec_val = mem_rdata - rssd_pkg::ONE;
  assign inc_val = mem_rdata + rssd_pkg::ONE;

  genvar gi;
  generate
    for (gi = 0; gi < rssd_pkg::DATA_W; gi++) begin : g_mask
      assign bit_mask[gi] = (bit_sel == 3'(gi));
    end
  endgenerate

  // Operand selection for the shared subtractor.
  always_comb begin
    alu_bus.acc = acc;
    alu_bus.mem = (op_code == rssd_pkg::OP_SUBTRACT_IMMEDIATE) ? imm_data : mem_rdata;
    case (op_code)
      rssd_pkg::OP_SUB_BORROW_TO_ACCUMULATOR,
      rssd_pkg::OP_SUB_BORROW_TO_MEMORY: alu_bus.carry_in = carry_flag;
      default: alu_bus.carry_in = 1'b1;
    endcase
  end

  // The skip dummy cycle holds busy high so the sequencer refuses a new op.
  always_comb begin
    next_acc = acc;
    next_carry_flag = carry_flag;
    next_zero_flag = zero_flag;
    next_nibble_carry_flag = nibble_carry_flag;
    next_sign_error_flag = sign_error_flag;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    next_skip_flush = 1'b0;
    next_busy = 1'b0;
    skip_cond = 1'b0;
    if (op_valid && !busy) begin
      case (op_code)
        rssd_pkg::OP_ROTATE_LEFT_VIA_CY_MEM: begin
          next_mem_we = 1'b1;
          next_mem_wdata = {mem_rdata[6:0], carry_flag};
          next_carry_flag = mem_rdata[rssd_pkg::MSB];
        end
        rssd_pkg::OP_ROTATE_LEFT_VIA_CY_TO_ACC: begin
          next_acc = {mem_rdata[6:0], carry_flag};
          next_carry_flag = mem_rdata[rssd_pkg::MSB];
        end
        rssd_pkg::OP_ROTATE_RIGHT_MEM: begin
          next_mem_we = 1'b1;
          next_mem_wdata = {mem_rdata[rssd_pkg::LSB], mem_rdata[7:1]};
        end
        rssd_pkg::OP_ROTATE_RIGHT_TO_ACC: begin
          next_acc = {mem_rdata[rssd_pkg::LSB], mem_rdata[7:1]};
        end
        rssd_pkg::OP_ROTATE_RIGHT_VIA_CARRY_MEM: begin
          next_mem_we = 1'b1;
          next_mem_wdata = {carry_flag, mem_rdata[7:1]};
          next_carry_flag = mem_rdata[rssd_pkg::LSB];
        end
        rssd_pkg::OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC: begin
          next_acc = {carry_flag, mem_rdata[7:1]};
          next_carry_flag = mem_rdata[rssd_pkg::LSB];
        end
        rssd_pkg::OP_SUB_BORROW_TO_ACCUMULATOR,
        rssd_pkg::OP_SUBTRACT_TO_ACC,
        rssd_pkg::OP_SUBTRACT_IMMEDIATE: begin
          next_acc = alu_bus.sum;
          next_carry_flag = alu_bus.carry_out;
          next_zero_flag = (alu_bus.sum == 8'h00);
          next_nibble_carry_flag = alu_bus.nibble_carry;
          next_sign_error_flag = alu_bus.sign_error;
        end
        rssd_pkg::OP_SUB_BORROW_TO_MEMORY,
        rssd_pkg::OP_SUBTRACT_TO_MEMORY: begin
          next_mem_we = 1'b1;
          next_mem_wdata = alu_bus.sum;
          next_carry_flag = alu_bus.carry_out;
          next_zero_flag = (alu_bus.sum == 8'h00);
          next_nibble_carry_flag = alu_bus.nibble_carry;
          next_sign_error_flag = alu_bus.sign_error;
        end
        rssd_pkg::OP_DECREMENT_SKIP_ZERO: begin
          next_mem_we = 1'b1;
          next_mem_wdata = dec_val;
          skip_cond = (dec_val == 8'h00);
        end
        rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
          next_acc = dec_val;
          skip_cond = (dec_val == 8'h00);
        end
        rssd_pkg::OP_SET_BYTE: begin
          next_mem_we = 1'b1;
          next_mem_wdata = rssd_pkg::SET_BYTE_VALUE;
        end
        rssd_pkg::OP_SET_BIT: begin
          next_mem_we = 1'b1;
          next_mem_wdata = mem_rdata | bit_mask;
        end
        rssd_pkg::OP_INCREMENT_SKIP_ZERO: begin
          next_mem_we = 1'b1;
          next_mem_wdata = inc_val;
          skip_cond = (inc_val == 8'h00);
        end
        rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_ZERO: begin
          next_acc = inc_val;
          skip_cond = (inc_val == 8'h00);
        end
        rssd_pkg::OP_BIT_TEST_SKIP_SET: begin
          skip_cond = |(mem_rdata & bit_mask);
        end
        rssd_pkg::OP_NIBBLE_SWAP_MEM: begin
          next_mem_we = 1'b1;
          next_mem_wdata = {mem_rdata[3:0], mem_rdata[7:4]};
        end
        rssd_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: begin
          next_acc = {mem_rdata[3:0], mem_rdata[7:4]};
        end
        default: begin
          next_mem_we = 1'b0;
        end
      endcase
      next_skip_flush = skip_cond;
      next_busy = skip_cond;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc <= rssd_pkg::ACC_RST;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      nibble_carry_flag <= 1'b0;
      sign_error_flag <= 1'b0;
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      skip_flush <= 1'b0;
      busy <= 1'b0;
    end else begin
      acc <= next_acc;
      carry_flag <= next_carry_flag;
      zero_flag <= next_zero_flag;
      nibble_carry_flag <= next_nibble_carry_flag;
      sign_error_flag <= next_sign_error_flag;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
      skip_flush <= next_skip_flush;
      busy <= next_busy;
    end
  end

endmodule : rssd_datapath

// ===== rssd_dp_assertions.sv
module rssd_dp_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Issue
  input wire logic op_valid,
  input wire rssd_pkg::rssd_op_e op_code,
  input wire logic [7:0] mem_rdata,
  input wire logic [2:0] bit_sel,
  // Results
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic nibble_carry_flag,
  input wire logic sign_error_flag,
  input wire logic skip_flush,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic take = op_valid && !busy;
  logic [7:0] m_q;
  logic [2:0] b_q;
  // Operands are kept a cycle so the checks can slice them without slicing a past value.
  always_ff @(posedge clk_sys) begin
    m_q <= mem_rdata;
    b_q <= bit_sel;
  end
  sequence skip_done;
    skip_flush && busy ##1 !busy && !skip_flush && !mem_we;
  endsequence
  flush_gap_a: assert property (skip_flush |-> skip_done) else $error("skip without one dummy cycle");
  busy_pair_a: assert property (busy |-> skip_flush) else $error("busy without skip");
  left_carry_mem_a: assert property (take && op_code == rssd_pkg::OP_ROTATE_LEFT_VIA_CY_MEM |=>
    mem_we && {carry_flag, mem_wdata} == {m_q, $past(carry_flag)}) else $error("left rotate via carry wrong");
  right_rotate_a: assert property (take && op_code == rssd_pkg::OP_ROTATE_RIGHT_MEM |=>
    mem_we && mem_wdata == {m_q[0], m_q[7:1]}) else $error("right rotate wrong");
  dec_skip_a: assert property (take && op_code == rssd_pkg::OP_DECREMENT_SKIP_ZERO |=>
    mem_we && mem_wdata == m_q - 8'h01 && skip_flush == (m_q == 8'h01)) else $error("decrement skip wrong");
  inc_acc_a: assert property (take && op_code == rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_ZERO |=>
    !mem_we && acc == m_q + 8'h01 && skip_flush == (m_q == 8'hFF)) else $error("increment to acc wrong");
  bit_test_a: assert property (take && op_code == rssd_pkg::OP_BIT_TEST_SKIP_SET |=>
    !mem_we && skip_flush == m_q[b_q]) else $error("bit test skip wrong");
  set_byte_a: assert property (take && op_code == rssd_pkg::OP_SET_BYTE |=>
    mem_we && mem_wdata == 8'hFF) else $error("set byte wrong");
  flags_kept_a: assert property (take && op_code inside {rssd_pkg::OP_ROTATE_RIGHT_MEM, rssd_pkg::OP_SET_BYTE,
    rssd_pkg::OP_DECREMENT_SKIP_ZERO, rssd_pkg::OP_NIBBLE_SWAP_MEM} |=>
    $stable({carry_flag, zero_flag, nibble_carry_flag, sign_error_flag})) else $error("flags changed");
endmodule : rssd_dp_assertions

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  rssd_pkg::rssd_op_e op_code = rssd_pkg::OP_NONE;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] imm_data = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic mem_we, carry_flag, zero_flag, nibble_carry_flag, sign_error_flag, skip_flush, busy;
  logic [7:0] mem_wdata, acc;
  int failures = 0;
  int samples_checked = 0;
  rssd_datapath i_dut (.clk_sys, .rst, .op_valid, .op_code, .mem_rdata, .imm_data, .bit_sel, .mem_we, .mem_wdata,
    .acc, .carry_flag, .zero_flag, .nibble_carry_flag, .sign_error_flag, .skip_flush, .busy);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Each issue leaves one idle cycle after it, so a skip's dummy cycle never swallows the next op.
  task automatic iss(input rssd_pkg::rssd_op_e o, input logic [7:0] m, input logic [2:0] b);
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = o;
    mem_rdata = m;
    bit_sel = b;
    @(negedge clk_sys);
    op_valid = 1'b0;
  endtask : iss
  task automatic t_rotate();
    iss(rssd_pkg::OP_ROTATE_RIGHT_VIA_CARRY_MEM, 8'h01, 3'h0);
    chk({mem_we, carry_flag, mem_wdata}, 16'h0300);
    iss(rssd_pkg::OP_ROTATE_LEFT_VIA_CY_MEM, 8'h4A, 3'h0);
    chk({mem_we, carry_flag, mem_wdata}, 16'h0295);
    iss(rssd_pkg::OP_ROTATE_LEFT_VIA_CY_TO_ACC, 8'h81, 3'h0);
    chk({mem_we, carry_flag, acc}, 16'h0102);
    iss(rssd_pkg::OP_ROTATE_RIGHT_MEM, 8'h03, 3'h0);
    chk({mem_we, carry_flag, mem_wdata}, 16'h0381);
    iss(rssd_pkg::OP_ROTATE_RIGHT_TO_ACC, 8'h02, 3'h0);
    chk({mem_we, carry_flag, acc}, 16'h0101);
    iss(rssd_pkg::OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC, 8'h02, 3'h0);
    chk({mem_we, carry_flag, acc}, 16'h0081);
    $display("rotate test done");
  endtask : t_rotate
  task automatic t_sub(input rssd_pkg::rssd_op_e o, input logic [7:0] a, input logic [7:0] m, input logic cin);
    logic ci;
    logic tm;
    logic [8:0] r;
    logic [4:0] h;
    ci = (o == rssd_pkg::OP_SUB_BORROW_TO_ACCUMULATOR || o == rssd_pkg::OP_SUB_BORROW_TO_MEMORY) ? cin : 1'b1;
    tm = (o == rssd_pkg::OP_SUB_BORROW_TO_MEMORY || o == rssd_pkg::OP_SUBTRACT_TO_MEMORY);
    r = {1'b0, a} + {1'b0, ~m} + ci;
    h = {1'b0, a[3:0]} + {1'b0, ~m[3:0]} + ci;
    imm_data = m;
    iss(rssd_pkg::OP_ROTATE_RIGHT_VIA_CARRY_MEM, {7'h00, cin}, 3'h0);
    iss(rssd_pkg::OP_ROTATE_RIGHT_TO_ACC, {a[6:0], a[7]}, 3'h0);
    iss(o, (o == rssd_pkg::OP_SUBTRACT_IMMEDIATE) ? ~m : m, 3'h0);
    chk({mem_we, sign_error_flag, zero_flag, nibble_carry_flag, carry_flag, tm ? mem_wdata : acc},
      {3'h0, tm, (a[7] != m[7]) && (r[7] != a[7]), r[7:0] == 8'h00, h[4], r[8], r[7:0]});
    $display("subtract test done");
  endtask : t_sub
  task automatic t_skip();
    iss(rssd_pkg::OP_DECREMENT_SKIP_ZERO, 8'h01, 3'h0);
    chk({skip_flush, busy, mem_we, mem_wdata}, 16'h0700);
    @(negedge clk_sys);
    chk({skip_flush, busy, mem_we}, 16'h0000);
    iss(rssd_pkg::OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h00, 3'h0);
    chk({skip_flush, busy, mem_we, acc}, 16'h00FF);
    iss(rssd_pkg::OP_INCREMENT_SKIP_ZERO, 8'hFF, 3'h0);
    chk({skip_flush, busy, mem_we, mem_wdata}, 16'h0700);
    iss(rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_ZERO, 8'h7F, 3'h0);
    chk({skip_flush, busy, mem_we, acc}, 16'h0080);
    iss(rssd_pkg::OP_INCREMENT_TO_ACC_SKIP_ZERO, 8'hFF, 3'h0);
    chk({skip_flush, busy, mem_we, acc}, 16'h0600);
    // An op held on the strobe through the dummy cycle must be refused.
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = rssd_pkg::OP_INCREMENT_SKIP_ZERO;
    mem_rdata = 8'hFF;
    @(negedge clk_sys);
    op_code = rssd_pkg::OP_SET_BYTE;
    chk({skip_flush, busy, mem_we, mem_wdata}, 16'h0700);
    @(negedge clk_sys);
    op_valid = 1'b0;
    chk({skip_flush, busy, mem_we, mem_wdata}, 16'h0000);
    $display("skip test done");
  endtask : t_skip
  task automatic t_bits();
    logic [7:0] m;
    m = 8'hA5;
    iss(rssd_pkg::OP_SET_BYTE, 8'h12, 3'h0);
    chk({mem_we, mem_wdata}, 16'h01FF);
    for (int i = 0; i < 8; i++) begin
      iss(rssd_pkg::OP_SET_BIT, ~(8'h01 << i), i[2:0]);
      chk({mem_we, mem_wdata}, 16'h01FF);
      iss(rssd_pkg::OP_BIT_TEST_SKIP_SET, m, i[2:0]);
      chk({mem_we, skip_flush}, {15'h0000, m[i]});
    end
    iss(rssd_pkg::OP_NIBBLE_SWAP_MEM, 8'h3C, 3'h0);
    chk({mem_we, mem_wdata}, 16'h01C3);
    iss(rssd_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 8'h9E, 3'h0);
    chk({mem_we, acc}, 16'h00E9);
    $display("bit test done");
  endtask : t_bits
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({acc, busy, mem_we, skip_flush, carry_flag, zero_flag}, 16'h0000);
    rst = 1'b0;
    t_rotate();
    t_sub(rssd_pkg::OP_SUB_BORROW_TO_ACCUMULATOR, 8'h00, 8'h00, 1'b0);
    t_sub(rssd_pkg::OP_SUB_BORROW_TO_MEMORY, 8'h10, 8'h0F, 1'b1);
    t_sub(rssd_pkg::OP_SUBTRACT_TO_ACC, 8'h05, 8'h05, 1'b0);
    t_sub(rssd_pkg::OP_SUBTRACT_TO_MEMORY, 8'h80, 8'h01, 1'b0);
    t_sub(rssd_pkg::OP_SUBTRACT_IMMEDIATE, 8'h12, 8'h34, 1'b1);
    t_skip();
    t_bits();
    give_verdict();
  end
  // About forty-five two-cycle issues are expected; the limit is over six times that.
  initial begin
    #5000;
    failures++;
    give_verdict();
  end
endmodule : testbench
bind rssd_datapath rssd_dp_assertions i_chk (.clk_sys, .rst, .op_valid, .op_code, .mem_rdata, .bit_sel, .mem_we,
  .mem_wdata, .acc, .carry_flag, .zero_flag, .nibble_carry_flag, .sign_error_flag, .skip_flush, .busy);
